// ### verilog/sksel_defines.svh
// Constants for the shift keying profile select block
`ifndef SKSEL_DEFINES_SVH
`define SKSEL_DEFINES_SVH
`define SKSEL_LVL_2 2'h0
`define SKSEL_LVL_4 2'h1
`define SKSEL_LVL_8 2'h2
`define SKSEL_LVL_16 2'h3
`define SKSEL_RAMP_OFF 2'h0
`define SKSEL_RAMP_PROF23 2'h1
`define SKSEL_RAMP_PROF3 2'h2
`define SKSEL_RAMP_SERIAL 2'h3
`define SKSEL_PPC_000 3'h0
`define SKSEL_PPC_011 3'h3
`define SKSEL_PPC_LOW2_01 2'h1
`define SKSEL_KEY_OFF 2'h0
`define SKSEL_KEY_AMP 2'h1
`define SKSEL_KEY_FREQ 2'h2
`define SKSEL_KEY_PHASE 2'h3
`define SKSEL_ADDR_FREQ0 8'h04
`define SKSEL_ADDR_PHASE0 8'h05
`define SKSEL_ADDR_AMP0 8'h06
`define SKSEL_ADDR_PROF1 8'h0a
`define SKSEL_FREQ_BITS 32
`define SKSEL_PHASE_BITS 14
`define SKSEL_AMP_BITS 10
`define SKSEL_RST_INDEX 4'h0
`endif

// ### verilog/sksel_pkg.sv
// Types for the shift keying profile select block
package sksel_pkg;
  typedef struct packed {
    logic [1:0] level;
    logic [2:0] profile_pin_config;
    logic [1:0] ramp_assign;
    logic [1:0] keyed_parameter_select;
    logic sweep_enable;
  } sksel_cfg_t;
  typedef struct packed {
    logic [3:0] index;
    logic [7:0] address;
    logic ramp_valid;
    logic amplitude_ramp_request;
    logic config_error;
  } sksel_sel_t;
  typedef enum logic [1:0] {
    SKSEL_KEY_OFF_S,
    SKSEL_KEY_AMP_S,
    SKSEL_KEY_FREQ_S,
    SKSEL_KEY_PHASE_S
  } sksel_key_t;
endpackage : sksel_pkg

// ### verilog/sksel_profile_select.sv
// Profile index and ramp request decoding from profile and serial pins
// Notes on behaviour
// - Level 00 without ramp: one pin picks the profile, pin config ignored.
// - Two-level, except ramp 01 config 011 (pin 0): profile pin 1 low gives profile 0, high gives profile 1.
// - Level 01, config 011: pins 0 and 1 form a 2-bit profile index.
// - Level 10, config x01: pins 0 to 2 form a 3-bit index.
// - Level 11, config x01: pins 0 to 3 form a 4-bit index.
// - Ramp 01: config 000 uses pin 1 and ramp pin 3; 011 pin 0, ramp pin 2.
// - Ramp 10: eight-level only; pins 0 to 2 select, pin 3 ramps.
// - Ramp 11: serial pins 1 to 3 ramp; levels 2, 4, 16 only.
// - Serial pins as ramp inputs force single-line serial mode.
// - Two-level serial ramping: pin 1 selects, serial pin 3 ramps.
// - Four-level serial: 000 pins 2,3 with serial 2; 011 pins 0,1 with serial 1.
// - Sixteen-level serial, x01: pins 0 to 3 select, serial pin 1 ramps.
// - Profile ramp pin low ramps up, high ramps down.
// - Keyed parameter: 00 off, 01 amplitude, 10 frequency, 11 phase.
// - Phase and amplitude words are MSB aligned; low bits ignored.
`timescale 1ns/1ps
`include "sksel_defines.svh"
module sksel_profile_select #(
  parameter int PROFILE_BITS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire sksel_pkg::sksel_cfg_t cfg,
  input wire logic [3:0] profile_pin,
  input wire logic [3:1] serial_pin,
  input wire logic [31:0] profile_word,
  output sksel_pkg::sksel_sel_t sel,
  output logic [1:0] keyed_parameter,
  output logic keying_enable,
  output logic serial_single_line,
  output logic [31:0] freq_word,
  output logic [13:0] phase_word,
  output logic [9:0] amp_word
);
  sksel_pkg::sksel_sel_t sel_reg;
  sksel_pkg::sksel_sel_t sel_next;
  logic [1:0] key_reg;
  logic [1:0] key_next;
  logic key_en_reg;
  logic key_en_next;
  logic single_reg;
  logic single_next;
  logic [31:0] freq_reg;
  logic [31:0] freq_next;
  logic [13:0] phase_reg;
  logic [13:0] phase_next;
  logic [9:0] amp_reg;
  logic [9:0] amp_next;
  logic [PROFILE_BITS-1:0] idx;
  logic ramp_bit;
  logic ramp_ok;
  logic bad;
  logic [13:0] phase_field;
  logic [9:0] amp_field;

  always_comb
  begin
    idx = '0;
    ramp_bit = 1'b0;
    ramp_ok = 1'b0;
    bad = 1'b0;
    case (cfg.ramp_assign)
      `SKSEL_RAMP_OFF:
      begin
        case (cfg.level)
          `SKSEL_LVL_2:
          begin
            idx[0] = profile_pin[1];
          end
          `SKSEL_LVL_4:
          begin
            idx[1:0] = {profile_pin[0], profile_pin[1]};
            bad = (cfg.profile_pin_config != `SKSEL_PPC_011);
          end
          `SKSEL_LVL_8:
          begin
            idx[2:0] = {profile_pin[0], profile_pin[1], profile_pin[2]};
            bad = (cfg.profile_pin_config[1:0] != `SKSEL_PPC_LOW2_01);
          end
          default:
          begin
            idx[3:0] = {profile_pin[0], profile_pin[1], profile_pin[2], profile_pin[3]};
            bad = (cfg.profile_pin_config[1:0] != `SKSEL_PPC_LOW2_01);
          end
        endcase
      end
      `SKSEL_RAMP_PROF23:
      begin
        ramp_ok = 1'b1;
        bad = (cfg.level != `SKSEL_LVL_2);
        if (cfg.profile_pin_config == `SKSEL_PPC_011)
        begin
          idx[0] = profile_pin[0];
          ramp_bit = profile_pin[2];
        end
        else
        begin
          idx[0] = profile_pin[1];
          ramp_bit = profile_pin[3];
          bad = bad | (cfg.profile_pin_config != `SKSEL_PPC_000);
        end
      end
      `SKSEL_RAMP_PROF3:
      begin
        ramp_ok = 1'b1;
        idx[2:0] = {profile_pin[0], profile_pin[1], profile_pin[2]};
        ramp_bit = profile_pin[3];
        bad = (cfg.level != `SKSEL_LVL_8) | (cfg.profile_pin_config[1:0] != `SKSEL_PPC_LOW2_01);
      end
      default:
      begin
        ramp_ok = 1'b1;
        case (cfg.level)
          `SKSEL_LVL_2:
          begin
            idx[0] = profile_pin[1];
            // Serial pin 3 low requests up, high requests down; pins 1 and 2 unused
            ramp_bit = serial_pin[3];
          end
          `SKSEL_LVL_4:
          begin
            if (cfg.profile_pin_config == `SKSEL_PPC_000)
            begin
              idx[1:0] = {profile_pin[2], profile_pin[3]};
              ramp_bit = serial_pin[2];
            end
            else
            begin
              idx[1:0] = {profile_pin[0], profile_pin[1]};
              ramp_bit = serial_pin[1];
              bad = (cfg.profile_pin_config != `SKSEL_PPC_011);
            end
          end
          `SKSEL_LVL_16:
          begin
            idx[3:0] = {profile_pin[0], profile_pin[1], profile_pin[2], profile_pin[3]};
            ramp_bit = serial_pin[1];
            bad = (cfg.profile_pin_config[1:0] != `SKSEL_PPC_LOW2_01);
          end
          `SKSEL_LVL_8:
          begin
            // Eight levels have no serial ramp mapping
            bad = 1'b1;
          end
          default:
          begin
            bad = 1'b1;
          end
        endcase
      end
    endcase
    // Sweep must be off while keying
    bad = bad | cfg.sweep_enable;
  end

  always_comb
  begin
    sel_next = sel_reg;
    sel_next.index = idx;
    sel_next.ramp_valid = ramp_ok;
    // Level low means ramp up, high means ramp down
    sel_next.amplitude_ramp_request = ramp_bit;
    sel_next.config_error = bad;
    if (idx == '0)
    begin
      case (cfg.keyed_parameter_select)
        `SKSEL_KEY_AMP:
        begin
          sel_next.address = `SKSEL_ADDR_AMP0;
        end
        `SKSEL_KEY_PHASE:
        begin
          sel_next.address = `SKSEL_ADDR_PHASE0;
        end
        default:
        begin
          // Keying off still points at the frequency word
          sel_next.address = `SKSEL_ADDR_FREQ0;
        end
      endcase
    end
    else
    begin
      sel_next.address = `SKSEL_ADDR_PROF1 + 8'(idx) - 8'h01;
    end
  end

  // Mode outputs follow the configuration one cycle later
  always_comb
  begin
    key_next = cfg.keyed_parameter_select;
    key_en_next = (cfg.keyed_parameter_select != `SKSEL_KEY_OFF) && !bad;
    single_next = (cfg.ramp_assign == `SKSEL_RAMP_SERIAL);
  end

  // Unused low bits of the stored word are dropped here
  sksel_msb_align #(
    .WORD_BITS(32),
    .FIELD_BITS(`SKSEL_PHASE_BITS)
  ) u_phase_align (
    .word(profile_word),
    .field(phase_field)
  );
  sksel_msb_align #(
    .WORD_BITS(32),
    .FIELD_BITS(`SKSEL_AMP_BITS)
  ) u_amp_align (
    .word(profile_word),
    .field(amp_field)
  );

  // Word read back for the previously presented address, one cycle late
  always_comb
  begin
    freq_next = freq_reg;
    phase_next = phase_reg;
    amp_next = amp_reg;
    case (key_reg)
      `SKSEL_KEY_FREQ:
      begin
        freq_next = profile_word;
      end
      `SKSEL_KEY_PHASE:
      begin
        phase_next = phase_field;
      end
      `SKSEL_KEY_AMP:
      begin
        amp_next = amp_field;
      end
      default:
      begin
        freq_next = freq_reg;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_reg <= '0;
      key_reg <= `SKSEL_KEY_OFF;
      key_en_reg <= 1'b0;
      single_reg <= 1'b0;
    end
    else
    begin
      sel_reg <= sel_next;
      key_reg <= key_next;
      key_en_reg <= key_en_next;
      single_reg <= single_next;
    end
  end

  // Own group, so a key change leaves the other words in place
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      freq_reg <= '0;
      phase_reg <= '0;
      amp_reg <= '0;
    end
    else
    begin
      freq_reg <= freq_next;
      phase_reg <= phase_next;
      amp_reg <= amp_next;
    end
  end

  assign sel = sel_reg;
  assign keyed_parameter = key_reg;
  assign keying_enable = key_en_reg;
  assign serial_single_line = single_reg;
  assign freq_word = freq_reg;
  assign phase_word = phase_reg;
  assign amp_word = amp_reg;
endmodule : sksel_profile_select

// Top bits of a wider stored word
// Storage is shared by all keyed parameters, so narrow words sit at the top
module sksel_msb_align #(
  parameter int WORD_BITS = 32,
  parameter int FIELD_BITS = 14
) (
  input wire logic [WORD_BITS-1:0] word,
  output logic [FIELD_BITS-1:0] field
);
  assign field = word[WORD_BITS-1 -: FIELD_BITS];
endmodule : sksel_msb_align

// ### bench/sksel_profile_select_assertions.sv
// Checker for profile select decoding
`timescale 1ns/1ps
module sksel_profile_select_assertions (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire sksel_pkg::sksel_cfg_t cfg,
  input wire logic [3:0] profile_pin,
  input wire logic [3:1] serial_pin,
  input wire sksel_pkg::sksel_sel_t sel,
  input wire logic keying_enable,
  input wire logic serial_single_line
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic [1:0] lv = cfg.level;
  wire logic [1:0] ra = cfg.ramp_assign;
  wire logic [2:0] pc = cfg.profile_pin_config;
  // Pin 0 is the index MSB
  wire logic [3:0] rv = {profile_pin[0], profile_pin[1], profile_pin[2], profile_pin[3]};
  property p_two; lv == 0 && ra == 0 |=> sel.index == {3'h0, $past(profile_pin[1])}; endproperty
  a_two: assert property (p_two) else $error("two level index");
  property p_four; lv == 1 && ra == 0 && pc == 3 |=> sel.index == {2'h0, $past(rv[3:2])}; endproperty
  a_four: assert property (p_four) else $error("four level index");
  property p_eight; lv == 2 && pc[1:0] == 1 |=> sel.index[2:0] == $past(rv[3:1]); endproperty
  a_eight: assert property (p_eight) else $error("eight level index");
  property p_sixteen; lv == 3 && pc[1:0] == 1 |=> sel.index == $past(rv); endproperty
  a_sixteen: assert property (p_sixteen) else $error("sixteen level index");
  property p_ramp_pin; ra == 1 && pc == 0 || ra == 2 |=> sel.amplitude_ramp_request == $past(profile_pin[3]); endproperty
  a_ramp_pin: assert property (p_ramp_pin) else $error("ramp pin");
  property p_ramp_ser; ra == 3 && lv == 1 && pc == 0 |=> sel.amplitude_ramp_request == $past(serial_pin[2]); endproperty
  a_ramp_ser: assert property (p_ramp_ser) else $error("serial ramp pin");
  property p_err; ra == 1 && lv != 0 |=> sel.config_error && !keying_enable; endproperty
  a_err: assert property (p_err) else $error("bad combo kept");
  property p_single; ra == 3 |=> serial_single_line; endproperty
  a_single: assert property (p_single) else $error("single line off");
  property p_addr; sel.index != 0 |-> sel.address == 8'h09 + sel.index; endproperty
  a_addr: assert property (p_addr) else $error("profile address");
endmodule : sksel_profile_select_assertions
bind sksel_profile_select sksel_profile_select_assertions u_chk (.sys_clk, .rst_b, .cfg, .profile_pin,
  .serial_pin, .sel, .keying_enable, .serial_single_line);

// ### bench/sksel_host_model.sv
// Host side model: profile storage and pin drive
`timescale 1ns/1ps
module sksel_host_model (
  input wire logic [7:0] address,
  input wire logic [3:0] pin_req,
  input wire logic [3:1] ser_req,
  output logic [3:0] profile_pin,
  output logic [3:1] serial_pin,
  output logic [31:0] profile_word
);
  // Word carries its own address so a wrong fetch shows
  assign profile_word = {address, ~address, address ^ 8'h5a, 8'hc3};
  assign profile_pin = pin_req;
  assign serial_pin = ser_req;
endmodule : sksel_host_model

// ### bench/sksel_profile_select_tb_top.sv
// Testbench for the profile select block
`timescale 1ns/1ps
module sksel_profile_select_tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  sksel_pkg::sksel_cfg_t cfg = '0;
  logic [3:0] pin_req = 4'h0;
  logic [3:1] ser_req = 3'h0;
  logic [3:0] profile_pin;
  logic [3:1] serial_pin;
  logic [31:0] profile_word;
  sksel_pkg::sksel_sel_t sel;
  logic keying_enable;
  logic [1:0] keyed_parameter;
  logic serial_single_line;
  logic [31:0] freq_word;
  logic [13:0] phase_word;
  logic [9:0] amp_word;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  sksel_profile_select u_dut (.sys_clk, .rst_b, .cfg, .profile_pin, .serial_pin, .profile_word, .sel,
    .keyed_parameter, .keying_enable, .serial_single_line, .freq_word, .phase_word, .amp_word);
  sksel_host_model u_host (.address(sel.address), .pin_req, .ser_req, .profile_pin, .serial_pin, .profile_word);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 500)
    begin
      bad_count++;
      finish_test();
    end
  end
  // Result read one falling edge later, after the sampling edge
  task automatic run(input logic [1:0] lv, ra, kp, input logic [2:0] pc, input logic [3:0] pins, input logic [3:1] ser);
    @(negedge sys_clk);
    cfg = '{lv, pc, ra, kp, 1'b0};
    pin_req = pins;
    ser_req = ser;
    @(negedge sys_clk);
  endtask : run
  function automatic logic [7:0] addr_of(input logic [3:0] idx, input logic [1:0] kp);
    if (idx != 4'h0)
      return 8'h09 + 8'(idx);
    return kp == 2'h3 ? 8'h05 : kp == 2'h1 ? 8'h06 : 8'h04;
  endfunction : addr_of
  function automatic logic [31:0] word_of(input logic [7:0] a);
    return {a, ~a, a ^ 8'h5a, 8'hc3};
  endfunction : word_of
  initial
  begin
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      run(2'h3, 2'h0, 2'h2, 3'h1, {i[0], i[1], i[2], i[3]}, 3'h0);
      check(sel.address, addr_of(i[3:0], 2'h2));
      @(negedge sys_clk);
      check(freq_word, word_of(addr_of(i[3:0], 2'h2)));
    end
    for (int k = 0; k < 4; k++)
    begin
      run(2'h0, 2'h0, k[1:0], 3'h5, 4'h0, 3'h0);
      check({sel.address, keying_enable}, {addr_of(4'h0, k[1:0]), k != 0});
      run(2'h0, 2'h0, k[1:0], 3'h5, 4'h2, 3'h0);
      check(sel.index, 4'h1);
      @(negedge sys_clk);
      if (k == 3) check(phase_word, word_of(8'h0a) >> 18);
      if (k == 1) check(amp_word, word_of(8'h0a) >> 22);
    end
    run(2'h1, 2'h0, 2'h2, 3'h3, 4'h3, 3'h0);
    check(sel.address, 8'h0c);
    run(2'h2, 2'h0, 2'h2, 3'h5, 4'h7, 3'h0);
    check(sel.address, 8'h10);
    run(2'h0, 2'h1, 2'h2, 3'h0, 4'ha, 3'h0);
    check({sel.index, sel.amplitude_ramp_request}, 5'h03);
    run(2'h0, 2'h1, 2'h2, 3'h3, 4'h1, 3'h0);
    check({sel.index, sel.amplitude_ramp_request}, 5'h02);
    run(2'h2, 2'h2, 2'h2, 3'h1, 4'hf, 3'h0);
    check({sel.index, sel.amplitude_ramp_request}, 5'h0f);
    run(2'h3, 2'h3, 2'h2, 3'h1, 4'hb, 3'h1);
    check({sel.address, sel.amplitude_ramp_request, serial_single_line}, 10'h05b);
    run(2'h1, 2'h3, 2'h2, 3'h0, 4'h4, 3'h2);
    check({sel.index, sel.amplitude_ramp_request}, 5'h05);
    run(2'h0, 2'h3, 2'h2, 3'h0, 4'h2, 3'h4);
    check({sel.index, sel.amplitude_ramp_request}, 5'h03);
    run(2'h2, 2'h1, 2'h2, 3'h0, 4'h0, 3'h0);
    check({sel.config_error, keying_enable}, 2'h2);
    run(2'h2, 2'h3, 2'h1, 3'h1, 4'h0, 3'h0);
    check({sel.config_error, keying_enable, sel.ramp_valid, serial_single_line}, 4'hb);
    run(2'h0, 2'h0, 2'h1, 3'h0, 4'h0, 3'h0);
    check({keyed_parameter, sel.ramp_valid, keying_enable}, 4'h5);
    cfg.sweep_enable = 1'b1;
    @(negedge sys_clk);
    check({sel.config_error, keying_enable}, 2'h2);
    finish_test();
  end
endmodule : sksel_profile_select_tb_top
